// ### dv/smp_regs_tb.sv
`timescale 1ns/1ps
module smp_regs_tb;
  import smp_pkg::*;
  // Clock, reset and bus drive
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  coef_raddr;
  logic [6:0]  coef_h_rd;
  logic [6:0]  coef_v_rd;
  smp_sdram_t        sdram_cfg;
  smp_field_t [3:0]  field_start;
  smp_size_t         deint_size;
  smp_rgb_t          blank_rgb;
  smp_scaler_t       scaler_cfg;
  smp_pan_t          pan_cfg;
  smp_rgb_t          border_rgb;
  int          n_mismatch;
  int          samples_checked;
  logic [31:0] rd;
  logic        err;

  smp_regs #(.ADDR_W(12)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .coef_raddr(coef_raddr), .coef_h_rd(coef_h_rd), .coef_v_rd(coef_v_rd),
    .sdram_cfg(sdram_cfg), .field_start(field_start), .deint_size(deint_size),
    .blank_rgb(blank_rgb), .scaler_cfg(scaler_cfg), .pan_cfg(pan_cfg),
    .border_rgb(border_rgb)
  );

  // Clock generation
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer, entered just after a rising edge, idles one cycle after
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      final_report();
    end else begin
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {2'b00, idx, 2'b00}, {24'h0000_00, d});
    check(32'(err), 32'h0000_0000);
  endtask

  task automatic peek(input logic [5:0] a, input logic [6:0] h, input logic [6:0] v);
    coef_raddr <= a;
    repeat (2) @(posedge pclk);
    check(32'(coef_h_rd), 32'(h));
    check(32'(coef_v_rd), 32'(v));
  endtask

  task automatic t_reset();
    check(32'(sdram_cfg), 32'h0000_0000);
    check(32'(scaler_cfg.ctrl), 32'h0000_0000);
    check(32'(border_rgb), 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_sdram();
    wr(8'h35, 8'hFF);
    wr(8'h36, 8'hA5);
    wr(8'h37, 8'h3C);
    check(32'(sdram_cfg.rcd), 32'h0000_000F);
    check(32'(sdram_cfg.cas), 32'h0000_0007);
    check(32'(sdram_cfg.rp), 32'h0000_0005);
    check(32'(sdram_cfg.rrd), 32'h0000_000A);
    check(32'(sdram_cfg.rc), 32'h0000_000C);
    check(32'(sdram_cfg.wr), 32'h0000_0003);
    apb(1'b0, 12'h0D4, 32'h0000_0000);
    check(rd, 32'h0000_007F);
    $display("test sdram done");
  endtask

  task automatic t_fields();
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      b = 8'h38 + 8'(3 * i);
      wr(b, 8'hA0 + 8'(i));
      wr(b + 8'h01, 8'hFD);
      wr(b + 8'h02, 8'h50 + 8'(i));
    end
    for (int i = 0; i < 4; i++) begin
      check(32'(field_start[i].row), {21'h0, 3'h5, 8'hA0 + 8'(i)});
      check(32'(field_start[i].col), {24'h0, 8'h50 + 8'(i)});
    end
    $display("test fields done");
  endtask

  task automatic t_sizes();
    wr(8'h44, 8'h12);
    wr(8'h45, 8'hFE);
    wr(8'h46, 8'h34);
    wr(8'h47, 8'hFB);
    wr(8'h58, 8'h56);
    wr(8'h59, 8'hF9);
    wr(8'h5A, 8'h78);
    wr(8'h5B, 8'hF7);
    wr(8'h5C, 8'h9A);
    wr(8'h5D, 8'hFA);
    wr(8'h5E, 8'hBC);
    wr(8'h5F, 8'hF5);
    check(32'(deint_size.height), 32'h0000_0612);
    check(32'(deint_size.width), 32'h0000_0B34);
    check(32'(pan_cfg.voff), 32'h0000_0156);
    check(32'(pan_cfg.hoff), 32'h0000_0778);
    check(32'(pan_cfg.size.height), 32'h0000_029A);
    check(32'(pan_cfg.size.width), 32'h0000_05BC);
    $display("test sizes done");
  endtask

  task automatic t_colours();
    for (int k = 0; k < 3; k++) begin
      wr(8'h48 + 8'(k), 8'hC1 + 8'(k));
      wr(8'h60 + 8'(k), 8'h3E - 8'(k));
    end
    check(32'(blank_rgb), 32'h00C1_C2C3);
    check(32'(border_rgb), 32'h003E_3D3C);
    $display("test colours done");
  endtask

  task automatic t_scaler();
    for (int b = 0; b < 7; b++) begin
      wr(8'h4B, 8'(1 << b));
      check(32'(scaler_cfg.ctrl), 32'(1 << b));
    end
    wr(8'h4C, 8'h11);
    wr(8'h4D, 8'hF2);
    wr(8'h4E, 8'hE3);
    wr(8'h4F, 8'h44);
    wr(8'h50, 8'hF5);
    wr(8'h51, 8'h86);
    wr(8'h52, 8'hFF);
    wr(8'h53, 8'hC8);
    wr(8'h54, 8'h6A);
    wr(8'h55, 8'h99);
    check(32'(scaler_cfg.vup_step), 32'h0000_0211);
    check(32'(scaler_cfg.vup_frac), 32'h0000_0063);
    check(32'(scaler_cfg.hup_step), 32'h0000_0544);
    check(32'(scaler_cfg.hup_frac), 32'h0000_0006);
    check(32'(scaler_cfg.vdn_step), 32'h0000_003F);
    check(32'(scaler_cfg.vdn_frac), 32'h0000_0048);
    check(32'(scaler_cfg.hdn_step), 32'h0000_002A);
    check(32'(scaler_cfg.hdn_frac), 32'h0000_0019);
    $display("test scaler done");
  endtask

  // Host sequence: enable, index, value, disable
  task automatic t_table();
    wr(8'h4B, 8'h00);
    wr(8'h56, 8'h45);
    wr(8'h57, 8'h55);
    peek(6'd5, 7'h00, 7'h00);
    wr(8'h4B, 8'h10);
    wr(8'h57, 8'h2A);
    peek(6'd5, 7'h2A, 7'h00);
    wr(8'h4B, 8'h20);
    wr(8'h56, 8'h3F);
    wr(8'h57, 8'hFF);
    wr(8'h4B, 8'h00);
    peek(6'd63, 7'h00, 7'h7F);
    peek(6'd5, 7'h2A, 7'h00);
    wr(8'h4B, 8'h30);
    wr(8'h56, 8'h01);
    wr(8'h57, 8'h33);
    wr(8'h4B, 8'h00);
    peek(6'd1, 7'h33, 7'h33);
    $display("test table done");
  endtask

  task automatic t_unmapped();
    apb(1'b1, 12'h0D0, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    apb(1'b1, 12'h18C, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    apb(1'b1, 12'h8D4, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    check(32'(sdram_cfg.rcd), 32'h0000_000F);
    $display("test unmapped done");
  endtask

  // Main sequence
  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    coef_raddr = 6'h00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_sdram();
    t_fields();
    t_sizes();
    t_colours();
    t_scaler();
    t_table();
    t_unmapped();
    final_report();
  end
endmodule

// ### pkg/smp_pkg.sv
// Summary of operation
// - Low nibble of the first timing byte gives row-to-column delay in clocks
// - Bits six to four of the first timing byte give the read latency
// - Second timing byte: precharge period low nibble, bank-to-bank spacing high nibble
// - Third timing byte: refresh/active period low nibble, write recovery high nibble
// - Four field buffer starts, each an 11-bit row and an 8-bit column
// - De-interlaced frame size: 11-bit height and 12-bit width
// - Blank screen colour from three 8-bit red, green, blue bytes
// - Scaler control bit four gates writes to the horizontal coefficient table
// - Scaler control bit five gates writes to the vertical coefficient table
// - Scaler control bit six hands the line memory to the downscaler
// - Vertical upscale: 12-bit step plus 7-bit fraction in hundredths
// - Horizontal upscale: 12-bit step plus 7-bit fraction in hundredths
// - Vertical downscale: 6-bit step plus 7-bit fraction in hundredths
// - Horizontal downscale: 6-bit step plus 7-bit fraction in hundredths
// - A 6-bit index selects the coefficient table entry to write
// - Writing the coefficient byte loads seven bits into the indexed entry
// - Panning places the picture at an 11-bit vertical offset
// - Panning places the picture at a 12-bit horizontal offset
// - Panned frame: 11-bit height and 12-bit width
// - Uncovered frame area uses the 8-bit red, green, blue border colour
package smp_pkg;
  localparam logic [7:0] IDX_SD1 = 8'h35;
  localparam logic [7:0] IDX_SD2 = 8'h36;
  localparam logic [7:0] IDX_SD3 = 8'h37;
  localparam logic [7:0] IDX_F1R = 8'h38;
  localparam logic [7:0] IDX_F1C = 8'h3A;
  localparam logic [7:0] IDX_F2R = 8'h3B;
  localparam logic [7:0] IDX_F2C = 8'h3D;
  localparam logic [7:0] IDX_F3R = 8'h3E;
  localparam logic [7:0] IDX_F3C = 8'h40;
  localparam logic [7:0] IDX_F4R = 8'h41;
  localparam logic [7:0] IDX_F4C = 8'h43;
  localparam logic [7:0] IDX_DFH = 8'h44;
  localparam logic [7:0] IDX_DLW = 8'h46;
  localparam logic [7:0] IDX_BLR = 8'h48;
  localparam logic [7:0] IDX_SCL = 8'h4B;
  localparam logic [7:0] IDX_VUS = 8'h4C;
  localparam logic [7:0] IDX_VUF = 8'h4E;
  localparam logic [7:0] IDX_HUS = 8'h4F;
  localparam logic [7:0] IDX_HUF = 8'h51;
  localparam logic [7:0] IDX_VDS = 8'h52;
  localparam logic [7:0] IDX_VDF = 8'h53;
  localparam logic [7:0] IDX_HDS = 8'h54;
  localparam logic [7:0] IDX_HDF = 8'h55;
  localparam logic [7:0] IDX_TIX = 8'h56;
  localparam logic [7:0] IDX_TVL = 8'h57;
  localparam logic [7:0] IDX_POV = 8'h58;
  localparam logic [7:0] IDX_POH = 8'h5A;
  localparam logic [7:0] IDX_PFH = 8'h5C;
  localparam logic [7:0] IDX_PFW = 8'h5E;
  localparam logic [7:0] IDX_BRR = 8'h60;
  localparam logic [7:0] IDX_BRB = 8'h62;
  localparam int         IDX_SHIFT = 2;
  localparam int         ADDR_MIN  = 11;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [6:0] TAB_RST = 7'h00;
  localparam int         TAB_DEPTH = 64;
  // Scaler control bit positions
  localparam int SC_HDN = 0;
  localparam int SC_VDN = 1;
  localparam int SC_HUP = 2;
  localparam int SC_VUP = 3;
  localparam int SC_HWE = 4;
  localparam int SC_VWE = 5;
  localparam int SC_LMD = 6;
  typedef struct packed {
    logic [3:0] rcd;
    logic [2:0] cas;
    logic [3:0] rp;
    logic [3:0] rrd;
    logic [3:0] rc;
    logic [3:0] wr;
  } smp_sdram_t;
  typedef struct packed {
    logic [10:0] row;
    logic [7:0]  col;
  } smp_field_t;
  typedef struct packed {
    logic [10:0] height;
    logic [11:0] width;
  } smp_size_t;
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } smp_rgb_t;
  typedef struct packed {
    logic [6:0]  ctrl;
    logic [11:0] vup_step;
    logic [6:0]  vup_frac;
    logic [11:0] hup_step;
    logic [6:0]  hup_frac;
    logic [5:0]  vdn_step;
    logic [6:0]  vdn_frac;
    logic [5:0]  hdn_step;
    logic [6:0]  hdn_frac;
  } smp_scaler_t;
  typedef struct packed {
    logic [10:0] voff;
    logic [11:0] hoff;
    smp_size_t   size;
  } smp_pan_t;
endpackage

// ### verilog/smp_regs.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module smp_regs
  import smp_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Coefficient table read port
  input  wire logic [5:0]        coef_raddr,
  output logic      [6:0]        coef_h_rd,
  output logic      [6:0]        coef_v_rd,
  // Configuration outputs
  output smp_sdram_t             sdram_cfg,
  output smp_field_t [3:0]       field_start,
  output smp_size_t              deint_size,
  output smp_rgb_t               blank_rgb,
  output smp_scaler_t            scaler_cfg,
  output smp_pan_t               pan_cfg,
  output smp_rgb_t               border_rgb
);

  // Refuse address buses too narrow to decode
  if (ADDR_W < ADDR_MIN) begin : g_chk
    $error("ADDR_W too small");
  end

  // Implemented bits of each byte, zero when unmapped
  function automatic logic [7:0] f_mask(input logic [7:0] i);
    logic [7:0] m;
    m = 8'h00;
    case (i)
      IDX_SD1, IDX_SCL, IDX_VUF, IDX_HUF,
      IDX_VDF, IDX_HDF, IDX_TVL: m = 8'h7F;
      IDX_F1R + 8'h01, IDX_F2R + 8'h01,
      IDX_F3R + 8'h01, IDX_F4R + 8'h01,
      IDX_DFH + 8'h01, IDX_POV + 8'h01,
      IDX_PFH + 8'h01: m = 8'h07;
      IDX_DLW + 8'h01, IDX_VUS + 8'h01,
      IDX_HUS + 8'h01, IDX_POH + 8'h01,
      IDX_PFW + 8'h01: m = 8'h0F;
      IDX_VDS, IDX_HDS, IDX_TIX: m = 8'h3F;
      default: begin
        if (i >= IDX_SD1 && i <= IDX_BRB) begin
          m = 8'hFF;
        end
      end
    endcase
    return m;
  endfunction

  logic [7:0]  cfg_r [IDX_SD1:IDX_BRB];
  logic [6:0]  htab_r [TAB_DEPTH];
  logic [6:0]  vtab_r [TAB_DEPTH];
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [6:0]  coef_h_r;
  logic [6:0]  coef_v_r;
  logic [7:0]  widx;
  logic [7:0]  wmask;
  logic        hit;
  logic        setup;
  logic        wr_go;
  logic        coef_go;
  logic [5:0]  tab_idx;
  logic [6:0]  coef_val;

  // Word index decode; each register takes one word
  assign widx  = paddr[IDX_SHIFT +: 8];
  assign wmask = f_mask(widx);
  assign hit   = (wmask != 8'h00) && ((paddr >> (IDX_SHIFT + 8)) == '0);
  assign setup = psel & ~penable;
  assign wr_go = psel & penable & pready_r & pwrite & hit;
  assign coef_go  = wr_go && (widx == IDX_TVL);
  assign tab_idx  = cfg_r[IDX_TIX][5:0];
  assign coef_val = pwdata[6:0];

  // Zero-wait answer, flagged in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~hit;
      if (setup && hit && !pwrite) begin
        prdata_r <= {24'h00_0000, cfg_r[widx]};
      end else if (setup) begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  // Byte store; unimplemented bits kept at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = IDX_SD1; i <= IDX_BRB; i++) begin
        cfg_r[i] <= REG_RST;
      end
    end else if (wr_go) begin
      cfg_r[widx] <= pwdata[7:0] & wmask;
    end
  end

  // Coefficient tables, each gated by its own enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < TAB_DEPTH; i++) begin
        htab_r[i] <= TAB_RST;
        vtab_r[i] <= TAB_RST;
      end
    end else if (coef_go) begin
      if (cfg_r[IDX_SCL][SC_HWE]) begin
        htab_r[tab_idx] <= coef_val;
      end
      if (cfg_r[IDX_SCL][SC_VWE]) begin
        vtab_r[tab_idx] <= coef_val;
      end
    end
  end

  // Registered table read for the scaler datapath
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coef_h_r <= TAB_RST;
      coef_v_r <= TAB_RST;
    end else begin
      coef_h_r <= htab_r[coef_raddr];
      coef_v_r <= vtab_r[coef_raddr];
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign coef_h_rd = coef_h_r;
  assign coef_v_rd = coef_v_r;

  // Memory sequencer timing fields
  assign sdram_cfg.rcd = cfg_r[IDX_SD1][3:0];
  assign sdram_cfg.cas = cfg_r[IDX_SD1][6:4];
  assign sdram_cfg.rp  = cfg_r[IDX_SD2][3:0];
  assign sdram_cfg.rrd = cfg_r[IDX_SD2][7:4];
  assign sdram_cfg.rc  = cfg_r[IDX_SD3][3:0];
  assign sdram_cfg.wr  = cfg_r[IDX_SD3][7:4];

  // Field buffer start locations
  assign field_start[0] = {cfg_r[IDX_F1R+1][2:0], cfg_r[IDX_F1R], cfg_r[IDX_F1C]};
  assign field_start[1] = {cfg_r[IDX_F2R+1][2:0], cfg_r[IDX_F2R], cfg_r[IDX_F2C]};
  assign field_start[2] = {cfg_r[IDX_F3R+1][2:0], cfg_r[IDX_F3R], cfg_r[IDX_F3C]};
  assign field_start[3] = {cfg_r[IDX_F4R+1][2:0], cfg_r[IDX_F4R], cfg_r[IDX_F4C]};

  // De-interlacer output size and blank colour
  assign deint_size.height = {cfg_r[IDX_DFH+1][2:0], cfg_r[IDX_DFH]};
  assign deint_size.width  = {cfg_r[IDX_DLW+1][3:0], cfg_r[IDX_DLW]};
  assign blank_rgb = {cfg_r[IDX_BLR], cfg_r[IDX_BLR+1], cfg_r[IDX_BLR+2]};

  // Scaler enables, table gates, line memory owner and steps
  assign scaler_cfg.ctrl     = cfg_r[IDX_SCL][6:0];
  assign scaler_cfg.vup_step = {cfg_r[IDX_VUS+1][3:0], cfg_r[IDX_VUS]};
  assign scaler_cfg.vup_frac = cfg_r[IDX_VUF][6:0];
  assign scaler_cfg.hup_step = {cfg_r[IDX_HUS+1][3:0], cfg_r[IDX_HUS]};
  assign scaler_cfg.hup_frac = cfg_r[IDX_HUF][6:0];
  assign scaler_cfg.vdn_step = cfg_r[IDX_VDS][5:0];
  assign scaler_cfg.vdn_frac = cfg_r[IDX_VDF][6:0];
  assign scaler_cfg.hdn_step = cfg_r[IDX_HDS][5:0];
  assign scaler_cfg.hdn_frac = cfg_r[IDX_HDF][6:0];

  // Panning geometry and border colour
  assign pan_cfg.voff = {cfg_r[IDX_POV+1][2:0], cfg_r[IDX_POV]};
  assign pan_cfg.hoff = {cfg_r[IDX_POH+1][3:0], cfg_r[IDX_POH]};
  assign pan_cfg.size.height = {cfg_r[IDX_PFH+1][2:0], cfg_r[IDX_PFH]};
  assign pan_cfg.size.width  = {cfg_r[IDX_PFW+1][3:0], cfg_r[IDX_PFW]};
  assign border_rgb = {cfg_r[IDX_BRR], cfg_r[IDX_BRR+1], cfg_r[IDX_BRR+2]};

  // Helpers for the table checks
  logic [6:0] h_old;
  logic [6:0] v_old;
  assign h_old = htab_r[tab_idx];
  assign v_old = vtab_r[tab_idx];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_go(logic [7:0] idx);
    wr_go && widx == idx;
  endsequence

  property p_ready;
    s_setup |=> pready && !pslverr == $past(hit) ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("bad APB answer");

  property p_rcd_cas;
    s_go(IDX_SD1) |=> sdram_cfg.rcd == $past(pwdata[3:0])
      && sdram_cfg.cas == $past(pwdata[6:4]);
  endproperty
  a_rcd_cas: assert property (p_rcd_cas) else $error("timing 1 wrong");

  property p_rp_rrd;
    s_go(IDX_SD2) |=> {sdram_cfg.rrd, sdram_cfg.rp} == $past(pwdata[7:0]);
  endproperty
  a_rp_rrd: assert property (p_rp_rrd) else $error("timing 2 wrong");

  property p_rc_wr;
    s_go(IDX_SD3) |=> {sdram_cfg.wr, sdram_cfg.rc} == $past(pwdata[7:0]);
  endproperty
  a_rc_wr: assert property (p_rc_wr) else $error("timing 3 wrong");

  property p_field_row;
    s_go(IDX_F2R + 8'h01) |=> field_start[1].row[10:8] == $past(pwdata[2:0]);
  endproperty
  a_field_row: assert property (p_field_row) else $error("row high wrong");

  property p_deint_w;
    s_go(IDX_DLW + 8'h01) |=> deint_size.width[11:8] == $past(pwdata[3:0]);
  endproperty
  a_deint_w: assert property (p_deint_w) else $error("width high wrong");

  property p_enables;
    s_go(IDX_SCL) |=> scaler_cfg.ctrl == $past(pwdata[6:0]) ##1
      $stable(scaler_cfg.ctrl) || $past(wr_go);
  endproperty
  a_enables: assert property (p_enables) else $error("control wrong");

  property p_h_write;
    coef_go && cfg_r[IDX_SCL][SC_HWE] |=> htab_r[$past(tab_idx)] == $past(coef_val);
  endproperty
  a_h_write: assert property (p_h_write) else $error("h table not written");

  property p_h_block;
    coef_go && !cfg_r[IDX_SCL][SC_HWE] |=> htab_r[$past(tab_idx)] == $past(h_old);
  endproperty
  a_h_block: assert property (p_h_block) else $error("h table written");

  property p_v_gate;
    coef_go |=> vtab_r[$past(tab_idx)] ==
      ($past(cfg_r[IDX_SCL][SC_VWE]) ? $past(coef_val) : $past(v_old));
  endproperty
  a_v_gate: assert property (p_v_gate) else $error("v table gate wrong");

  property p_vdn;
    s_go(IDX_VDS) |=> scaler_cfg.vdn_step == $past(pwdata[5:0]);
  endproperty
  a_vdn: assert property (p_vdn) else $error("down step wrong");

  property p_pan;
    s_go(IDX_POH + 8'h01) |=> pan_cfg.hoff[11:8] == $past(pwdata[3:0]) ##1
      pan_cfg.hoff[11:8] == $past(pan_cfg.hoff[11:8], 1) || $past(wr_go);
  endproperty
  a_pan: assert property (p_pan) else $error("offset wrong");

  // Byte-to-field checks for a selection of the remaining registers
  property p_field_col;
    s_go(IDX_F1C) |=> field_start[0].col == $past(pwdata[7:0]);
  endproperty
  a_field_col: assert property (p_field_col) else $error("column wrong");

  property p_field_low;
    s_go(IDX_F4R) |=> field_start[3].row[7:0] == $past(pwdata[7:0]);
  endproperty
  a_field_low: assert property (p_field_low) else $error("row low wrong");

  property p_deint_h;
    s_go(IDX_DFH + 8'h01) |=> deint_size.height[10:8] == $past(pwdata[2:0]);
  endproperty
  a_deint_h: assert property (p_deint_h) else $error("height high wrong");

  property p_blank_g;
    s_go(IDX_BLR + 8'h01) |=> blank_rgb.g == $past(pwdata[7:0]);
  endproperty
  a_blank_g: assert property (p_blank_g) else $error("blank green wrong");

  property p_blank_b;
    s_go(IDX_BLR + 8'h02) |=> blank_rgb.b == $past(pwdata[7:0]);
  endproperty
  a_blank_b: assert property (p_blank_b) else $error("blank blue wrong");

  property p_vup_hi;
    s_go(IDX_VUS + 8'h01) |=> scaler_cfg.vup_step[11:8] == $past(pwdata[3:0]);
  endproperty
  a_vup_hi: assert property (p_vup_hi) else $error("v up step wrong");

  property p_vup_frac;
    s_go(IDX_VUF) |=> scaler_cfg.vup_frac == $past(pwdata[6:0]);
  endproperty
  a_vup_frac: assert property (p_vup_frac) else $error("v up fraction wrong");

  property p_hup_lo;
    s_go(IDX_HUS) |=> scaler_cfg.hup_step[7:0] == $past(pwdata[7:0]);
  endproperty
  a_hup_lo: assert property (p_hup_lo) else $error("h up step wrong");

  property p_hup_frac;
    s_go(IDX_HUF) |=> scaler_cfg.hup_frac == $past(pwdata[6:0]);
  endproperty
  a_hup_frac: assert property (p_hup_frac) else $error("h up fraction wrong");

  property p_vdn_frac;
    s_go(IDX_VDF) |=> scaler_cfg.vdn_frac == $past(pwdata[6:0]);
  endproperty
  a_vdn_frac: assert property (p_vdn_frac) else $error("v down fraction wrong");

  property p_hdn;
    s_go(IDX_HDS) |=> scaler_cfg.hdn_step == $past(pwdata[5:0]);
  endproperty
  a_hdn: assert property (p_hdn) else $error("h down step wrong");

  property p_hdn_frac;
    s_go(IDX_HDF) |=> scaler_cfg.hdn_frac == $past(pwdata[6:0]);
  endproperty
  a_hdn_frac: assert property (p_hdn_frac) else $error("h down fraction wrong");

  property p_index;
    s_go(IDX_TIX) |=> tab_idx == $past(pwdata[5:0]);
  endproperty
  a_index: assert property (p_index) else $error("table index wrong");

  property p_voff;
    s_go(IDX_POV + 8'h01) |=> pan_cfg.voff[10:8] == $past(pwdata[2:0]);
  endproperty
  a_voff: assert property (p_voff) else $error("v offset wrong");

  property p_pan_h;
    s_go(IDX_PFH) |=> pan_cfg.size.height[7:0] == $past(pwdata[7:0]);
  endproperty
  a_pan_h: assert property (p_pan_h) else $error("panned height wrong");

  property p_pan_w;
    s_go(IDX_PFW + 8'h01) |=> pan_cfg.size.width[11:8] == $past(pwdata[3:0]);
  endproperty
  a_pan_w: assert property (p_pan_w) else $error("panned width wrong");

  property p_border_r;
    s_go(IDX_BRR) |=> border_rgb.r == $past(pwdata[7:0]);
  endproperty
  a_border_r: assert property (p_border_r) else $error("border red wrong");

  property p_border_b;
    s_go(IDX_BRR + 8'h02) |=> border_rgb.b == $past(pwdata[7:0]);
  endproperty
  a_border_b: assert property (p_border_b) else $error("border blue wrong");

  property p_refuse;
    psel && penable && pwrite && !hit |=> $stable(sdram_cfg);
  endproperty
  a_refuse: assert property (p_refuse) else $error("unmapped write landed");

  property p_read;
    s_setup && hit && !pwrite |=> prdata == {24'h00_0000, $past(cfg_r[widx])};
  endproperty
  a_read: assert property (p_read) else $error("read data wrong");

  property p_coef_rd;
    coef_h_rd == $past(htab_r[coef_raddr]) && coef_v_rd == $past(vtab_r[coef_raddr]);
  endproperty
  a_coef_rd: assert property (p_coef_rd) else $error("table read wrong");

endmodule
